// ### hw/peb_fifo.sv
// small synchronous fifo for queued write requests
// assumes one clock and an active low asynchronous reset
`timescale 1ns/1ps
module peb_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
) (
  input wire logic core_clk, // core clock
  input wire logic arst_n, // async reset, low
  input wire logic in_valid, // write side valid
  output logic in_ready, // write side ready
  input wire logic [WIDTH-1:0] in_data, // write side word
  output logic out_valid, // read side valid
  input wire logic out_ready, // read side ready
  output logic [WIDTH-1:0] out_data // read side word
);
  localparam int AW = $clog2(DEPTH); // storage index width, pointers one bit wider
  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic [AW:0] wr_q; // write pointer
  logic [AW:0] rd_q; // read pointer
  logic push; // word enters
  logic pop; // word leaves
  logic ready_q; // room for one more word
  logic [AW:0] wr_d; // write pointer next
  logic [AW:0] rd_d; // read pointer next
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign wr_d = wr_q + (AW+1)'(push);
  assign rd_d = rd_q + (AW+1)'(pop);
  // ready comes from a flop so the top-level port needs no gate behind it
  assign in_ready = ready_q;
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  // storage write
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  // pointers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      ready_q <= 1'b1;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      ready_q <= (wr_d - rd_d) != (AW+1)'(DEPTH); // not full after this edge
    end
  end
endmodule

// ### hw/peb_host.sv
// host controller driving the eeprom strobes, address and data pins
// assumes pins are async to core_clk; user side is on core_clk
`timescale 1ns/1ps
module peb_host
  import peb_pkg::*;
#(
  parameter int WC_CYCLES = WC_CYC,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic core_clk, // core clock
  input wire logic arst_n, // async reset, low
  input wire logic wr_valid, // queue a byte write
  output logic wr_ready, // write queue has room
  input wire logic [peb_pkg::ADDR_W-1:0] wr_addr, // write address
  input wire logic [peb_pkg::DATA_W-1:0] wr_data, // write byte
  input wire logic rd_req, // read pulse, taken when rd_busy low
  input wire logic [peb_pkg::ADDR_W-1:0] rd_addr, // read address
  output logic rd_busy, // read pending or running
  output logic rd_done, // read data valid pulse
  output logic [peb_pkg::DATA_W-1:0] rd_data, // read byte
  output logic wr_busy, // internal write in progress
  output logic wr_timeout, // write not done in time pulse
  output logic [peb_pkg::ADDR_W-1:0] mem_addr, // address pins
  output logic mem_ce_n, // chip select, low
  output logic mem_oe_n, // output enable, low
  output logic mem_we_n, // write strobe, low
  output logic [peb_pkg::DATA_W-1:0] mem_dq_o, // data out
  output logic mem_dq_oe, // data drive enable
  input wire logic [peb_pkg::DATA_W-1:0] mem_dq_i // data in pins
);
  localparam int FW = ADDR_W + DATA_W; // fifo word width
  peb_state_t st_q; // controller state
  logic [CNT_W-1:0] cnt_q; // phase timer
  logic [CNT_W-1:0] wc_q; // internal write timer
  logic [DATA_W-1:0] s1_q; // sync stage one
  logic [DATA_W-1:0] s2_q; // sync stage two
  logic [DATA_W-1:0] last_q; // expected data for poll
  logic rd_pend_q; // read waiting
  logic [ADDR_W-1:0] rd_addr_q; // held read address
  logic f_valid; // fifo has word
  logic f_ready; // fifo pop
  logic [FW-1:0] f_data; // fifo word
  logic tmo; // internal write overrun

  peb_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_addr, wr_data}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // pop only when a write strobe phase is starting
  assign f_ready = (st_q == PEB_IDLE) && !wr_busy && !rd_pend_q && f_valid;
  assign tmo = wr_busy && (wc_q == CNT_W'(WC_CYCLES));

  // data pins pass two flops before use
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= mem_dq_i;
      s2_q <= s1_q;
    end
  end

  // read request capture
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= '0;
    end else if (rd_req && !rd_pend_q) begin
      rd_pend_q <= 1'b1;
      rd_addr_q <= rd_addr;
    end else if (st_q == PEB_RREL && cnt_q == '0) begin
      rd_pend_q <= 1'b0;
    end
  end

  // internal write tracking, ended by poll match or timeout
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_busy <= 1'b0;
      wc_q <= '0;
      wr_timeout <= 1'b0;
    end else begin
      wr_timeout <= tmo;
      if (st_q == PEB_WREC && cnt_q == '0) begin
        wr_busy <= 1'b1; // see R04
        wc_q <= '0;
      end else if (wr_busy) begin
        if (tmo) begin
          wr_busy <= 1'b0; // see R05
        end else begin
          wc_q <= wc_q + 1'b1; // timer stops at its limit
          if (st_q == PEB_POLL && cnt_q == '0 && s2_q[DATA_W-1] == last_q[DATA_W-1]) begin
            wr_busy <= 1'b0; // see R09
          end
        end
      end
    end
  end

  // strobe sequencer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= PEB_IDLE;
      cnt_q <= '0;
      mem_ce_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_we_n <= 1'b1;
      mem_dq_oe <= 1'b0;
      mem_dq_o <= '0;
      mem_addr <= '0;
      rd_done <= 1'b0;
      rd_data <= '0;
      rd_busy <= 1'b0;
      last_q <= '0;
    end else begin
      rd_done <= 1'b0;
      rd_busy <= rd_pend_q || (rd_req && !rd_pend_q);
      case (st_q)
        PEB_IDLE: begin
          mem_ce_n <= 1'b1; // see R01
          mem_oe_n <= 1'b1; // see R07
          mem_we_n <= 1'b1;
          mem_dq_oe <= 1'b0;
          if (wr_busy) begin
            if (!tmo) begin
              // address pins still hold the byte just written
              mem_ce_n <= 1'b0; // see R08
              mem_oe_n <= 1'b0;
              cnt_q <= CNT_W'(RC_CYC + 2);
              st_q <= PEB_POLL;
            end
          end else if (rd_pend_q) begin
            mem_addr <= rd_addr_q;
            mem_ce_n <= 1'b0; // see R02
            mem_oe_n <= 1'b0;
            cnt_q <= CNT_W'(RC_CYC + 2); // see R09
            st_q <= PEB_RD;
          end else if (f_valid) begin
            mem_addr <= f_data[FW-1:DATA_W];
            mem_dq_o <= f_data[DATA_W-1:0];
            last_q <= f_data[DATA_W-1:0];
            mem_dq_oe <= 1'b1;
            mem_ce_n <= 1'b0; // see R02
            mem_we_n <= 1'b0; // see R06
            cnt_q <= CNT_W'(WP_CYC);
            st_q <= PEB_WR;
          end
        end
        PEB_RD: begin
          if (cnt_q == '0) begin
            rd_data <= s2_q;
            rd_done <= 1'b1;
            mem_ce_n <= 1'b1;
            mem_oe_n <= 1'b1;
            cnt_q <= CNT_W'(OHZ_CYC); // see R03
            st_q <= PEB_RREL;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        PEB_RREL: begin
          if (cnt_q == '0) st_q <= PEB_IDLE;
          else cnt_q <= cnt_q - 1'b1;
        end
        PEB_WR: begin
          if (cnt_q == '0) begin
            mem_we_n <= 1'b1;
            cnt_q <= CNT_W'(WPH_CYC);
            st_q <= PEB_WREC;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        PEB_WREC: begin
          if (cnt_q == '0) begin
            mem_ce_n <= 1'b1;
            mem_dq_oe <= 1'b0;
            st_q <= PEB_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        PEB_POLL: begin
          if (cnt_q == '0) begin
            mem_ce_n <= 1'b1;
            mem_oe_n <= 1'b1;
            cnt_q <= CNT_W'(OHZ_CYC); // see R03
            st_q <= PEB_PREL;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        PEB_PREL: begin
          if (cnt_q == '0) st_q <= PEB_IDLE;
          else cnt_q <= cnt_q - 1'b1;
        end
        default: begin
          st_q <= PEB_IDLE;
        end
      endcase
    end
  end

  // never drive data while output enable is low
  property p_no_contention;
    @(posedge core_clk) disable iff (!arst_n) !(mem_dq_oe && !mem_oe_n);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("data driven during read"); // see R02

  // write strobe only under chip select
  property p_we_needs_ce;
    @(posedge core_clk) disable iff (!arst_n) !mem_we_n |-> !mem_ce_n;
  endproperty
  a_we_needs_ce: assert property (p_we_needs_ce) else $error("write without select"); // see R01

  // write pulse lasts its full width
  sequence s_we_fall;
    $fell(mem_we_n);
  endsequence
  property p_we_width;
    @(posedge core_clk) disable iff (!arst_n) s_we_fall |-> !mem_we_n [*8] ##1 !mem_we_n [*2];
  endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse short"); // see R06

  // reads hold the strobes for the read cycle
  sequence s_oe_fall;
    $fell(mem_oe_n);
  endsequence
  sequence s_oe_low8;
    !mem_oe_n [*8];
  endsequence
  property p_read_width;
    @(posedge core_clk) disable iff (!arst_n)
      s_oe_fall |-> s_oe_low8 ##1 s_oe_low8 ##1 s_oe_low8;
  endproperty
  a_read_width: assert property (p_read_width) else $error("read cycle short"); // see R09

  // after a write, no new write until busy ends
  property p_write_gap;
    @(posedge core_clk) disable iff (!arst_n) wr_busy |-> mem_we_n;
  endproperty
  a_write_gap: assert property (p_write_gap) else $error("write during internal write"); // see R04

  // busy never lasts beyond the write limit
  property p_busy_bound;
    @(posedge core_clk) disable iff (!arst_n) wc_q <= CNT_W'(WC_CYCLES);
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("write timer overrun"); // see R05

  // after a read the strobes stay high for release
  property p_release;
    @(posedge core_clk) disable iff (!arst_n) $rose(mem_oe_n) |-> mem_oe_n [*6];
  endproperty
  a_release: assert property (p_release) else $error("release gap short"); // see R03

  // a poll is a read with select low
  property p_poll_read;
    @(posedge core_clk) disable iff (!arst_n) (st_q == PEB_POLL) |-> (!mem_ce_n && mem_we_n);
  endproperty
  a_poll_read: assert property (p_poll_read) else $error("poll not a read"); // see R08
endmodule

// ### hw/peb_pkg.sv
// constants for the parallel eeprom host controller
// assumes a 200 MHz core clock and one byte-wide eeprom on the pins
// Functional notes
// R01 - chip select high means standby, no writes
// R02 - strobe combinations select read or write
// R03 - device releases data when select rises
// R04 - wait write time or poll before access
// R05 - device finishes internal write within 5 ms
// R06 - page byte loads use single write timing
// R07 - output strobe between loads, select high
// R08 - output strobe with select low polls
// R09 - polls use full read cycle timing
package peb_pkg;
  localparam int CLK_MHZ = 200; // core clock rate
  localparam int ADDR_W = 13; // address width
  localparam int DATA_W = 8; // data width
  localparam int T_RC_NS = 120; // read cycle least time
  localparam int T_WP_NS = 50; // write pulse least width
  localparam int T_WPH_NS = 50; // write strobe high recovery
  localparam int T_OHZ_NS = 30; // output release longest
  localparam int T_WC_MS = 5; // internal_write_time longest
  localparam int RC_CYC = (T_RC_NS * CLK_MHZ + 999) / 1000; // read cycles
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000; // write pulse cycles
  localparam int WPH_CYC = (T_WPH_NS * CLK_MHZ + 999) / 1000; // recovery cycles
  localparam int OHZ_CYC = (T_OHZ_NS * CLK_MHZ + 999) / 1000; // release cycles
  localparam int WC_CYC = T_WC_MS * CLK_MHZ * 1000; // internal write cycles
  localparam int CNT_W = 24; // timer width
  typedef enum logic [2:0] {
    PEB_IDLE = 3'b000,
    PEB_RD = 3'b001,
    PEB_RREL = 3'b010,
    PEB_WR = 3'b011,
    PEB_WREC = 3'b100,
    PEB_POLL = 3'b101,
    PEB_PREL = 3'b110
  } peb_state_t;
endpackage

// ### verification/peb_mem_model.sv
// behavioural byte-wide eeprom seen from its pins
// assumes the bench resolves the shared data pins from both enables
`timescale 1ns/1ps
module peb_mem_model #(
  parameter int BUSY_NS = 600, // internal write length
  parameter int ACC_NS = 100, // read access time
  parameter logic [7:0] FILL = 8'hFF // erased contents
) (
  input wire logic [peb_pkg::ADDR_W-1:0] mem_addr, // address pins
  input wire logic mem_ce_n, // chip select, low
  input wire logic mem_oe_n, // output enable, low
  input wire logic mem_we_n, // write strobe, low
  input wire logic [peb_pkg::DATA_W-1:0] dq_in, // data pins as seen
  input wire logic hang, // bench stretches the write
  output logic [peb_pkg::DATA_W-1:0] dq_out, // read data
  output logic dq_drv // device drives data pins
);
  import peb_pkg::*;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // array
  logic [ADDR_W-1:0] a_l; // latched address
  logic [DATA_W-1:0] d_l; // latched data
  logic [DATA_W-1:0] last = 8'h00; // last written byte
  logic busy = 1'b0; // internal write running
  logic valid = 1'b0; // access time met
  logic armed = 1'b0; // a real write strobe was seen
  wire wr_act = !mem_ce_n && !mem_we_n && mem_oe_n;
  wire rd_act = !mem_ce_n && !mem_oe_n && mem_we_n;
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = FILL;
  end
  // follow address and data while the write is open
  always @(wr_act or mem_addr or dq_in) begin
    if (wr_act) begin
      a_l = mem_addr;
      d_l = dq_in;
      armed = 1'b1;
    end
  end
  // strobe rise starts a self-timed write; loads while busy are dropped
  // armed keeps the unknown-to-low step at power-up from posing as a write
  always @(negedge wr_act) begin
    if (!busy && armed) begin
      armed = 1'b0;
      mem[a_l] = d_l;
      last = d_l;
      busy = 1'b1;
      #(BUSY_NS);
      wait (!hang);
      busy = 1'b0;
    end
  end
  // data is garbage until the access time has run
  always @(posedge rd_act) begin
    valid = 1'b0;
    #(ACC_NS);
    valid = 1'b1;
  end
  assign dq_drv = rd_act;
  // while busy a read shows bit 7 inverted
  always_comb begin
    if (busy) dq_out = {~last[7], last[6:0]};
    else dq_out = mem[mem_addr];
    if (!valid) dq_out = ~dq_out;
  end
endmodule

// ### verification/tb.sv
// self-checking bench for the eeprom host controller
// assumes the model file and the design files are compiled first
`timescale 1ns/1ps
module tb;
  import peb_pkg::*;
  localparam int WCC = 200; // shortened write limit
  logic core_clk = 1'b0; // core clock
  logic arst_n = 1'b0; // reset, low
  logic wr_valid = 1'b0; // write request
  logic wr_ready; // write room
  logic [ADDR_W-1:0] wr_addr = 13'h0000; // write address
  logic [DATA_W-1:0] wr_data = 8'h00; // write byte
  logic rd_req = 1'b0; // read pulse
  logic [ADDR_W-1:0] rd_addr = 13'h0000; // read address
  logic rd_busy, rd_done, wr_busy, wr_timeout; // status
  logic [DATA_W-1:0] rd_data, mem_dq_o, mem_dq_i, dq_m; // data
  logic [DATA_W-1:0] bus_last = 8'h00; // last driven bus value
  logic [ADDR_W-1:0] mem_addr; // address pins
  logic mem_ce_n, mem_oe_n, mem_we_n, mem_dq_oe, drv_m; // strobes
  logic hang = 1'b0; // stretch model write
  logic saw_full = 1'b0; // queue refused once
  int mismatches = 0;
  int total_checks = 0;
  int tmo_seen = 0; // timeout pulses
  peb_host #(.WC_CYCLES(WCC), .FIFO_DEPTH(16)) u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_busy(rd_busy), .rd_done(rd_done),
    .rd_data(rd_data), .wr_busy(wr_busy), .wr_timeout(wr_timeout), .mem_addr(mem_addr),
    .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .mem_dq_o(mem_dq_o),
    .mem_dq_oe(mem_dq_oe), .mem_dq_i(mem_dq_i));
  peb_mem_model u_mem (.mem_addr(mem_addr), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n), .dq_in(mem_dq_i), .hang(hang), .dq_out(dq_m), .dq_drv(drv_m));
  // released bus shows the inverse of its last level
  assign mem_dq_i = mem_dq_oe ? mem_dq_o : (drv_m ? dq_m : ~bus_last);
  initial forever #2.5 core_clk = ~core_clk;
  // bus history, contention watch and timeout count
  always @(posedge core_clk) begin
    if (mem_dq_oe === 1'b1 || drv_m) bus_last <= mem_dq_i;
    if (mem_dq_oe === 1'b1 && drv_m) bad("bus contention");
    if (wr_timeout === 1'b1) tmo_seen++;
  end
  task automatic bad(input string msg);
    mismatches++;
    $display("BAD %0t %s", $time, msg);
  endtask
  task automatic do_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge core_clk);
    wr_valid = 1'b1;
    wr_addr = a;
    wr_data = d;
    while (wr_ready !== 1'b1) begin
      saw_full = 1'b1;
      @(negedge core_clk);
    end
    @(negedge core_clk);
    wr_valid = 1'b0;
  endtask
  // idle means no select and no busy for 40 cycles
  task automatic wait_idle();
    int q;
    q = 0;
    while (q < 40) begin
      @(negedge core_clk);
      q = (wr_busy === 1'b0 && mem_ce_n === 1'b1) ? q + 1 : 0;
    end
  endtask
  task automatic do_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(negedge core_clk);
    while (rd_busy !== 1'b0) @(negedge core_clk);
    rd_req = 1'b1;
    rd_addr = a;
    @(negedge core_clk);
    rd_req = 1'b0;
    while (rd_done !== 1'b1) @(negedge core_clk);
    total_checks++;
    if (rd_data !== e) bad("read data");
  endtask
  task automatic t_single();
    do_write(13'h0000, 8'hA5);
    wait_idle();
    do_read(13'h0000, 8'hA5);
    do_write(13'h1FFF, 8'h5A);
    wait_idle();
    do_read(13'h1FFF, 8'h5A);
    do_read(13'h0100, 8'hFF);
    $display("single write and read done");
  endtask
  task automatic t_busy_read();
    do_write(13'h0010, 8'h3C);
    repeat (40) @(negedge core_clk);
    total_checks++;
    if (wr_busy !== 1'b1) bad("no busy after write");
    do_read(13'h0010, 8'h3C);
    $display("read behind write done");
  endtask
  task automatic t_fill();
    saw_full = 1'b0;
    for (int i = 0; i < 18; i++) do_write(13'h0040 + 13'(i), 8'hC0 + 8'(i));
    total_checks++;
    if (saw_full !== 1'b1) bad("queue never refused");
    wait_idle();
    for (int i = 0; i < 18; i++) do_read(13'h0040 + 13'(i), 8'hC0 + 8'(i));
    $display("queue fill done");
  endtask
  task automatic t_timeout();
    total_checks++;
    if (tmo_seen != 0) bad("early timeout");
    hang = 1'b1;
    do_write(13'h0200, 8'h81);
    repeat (WCC + 100) @(negedge core_clk);
    total_checks++;
    if (tmo_seen != 1) bad("no write timeout");
    hang = 1'b0;
    wait_idle();
    do_read(13'h0200, 8'h81);
    $display("write timeout done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    arst_n = 1'b1;
    t_single();
    t_busy_read();
    t_fill();
    t_timeout();
    print_verdict();
  end
  // watchdog at 60000 cycles
  initial begin
    #300000;
    bad("watchdog expired");
    print_verdict();
  end
endmodule
